// ===== verilog/nrps_cfg.svh
// constants for the nand sequencer host controller
// assumes inclusion by the package and the controller modules
`ifndef NRPS_CFG_SVH
`define NRPS_CFG_SVH
`define NRPS_CMD_READ_SETUP   8'h00
`define NRPS_CMD_READ_START   8'h30
`define NRPS_CMD_READ_CACHE   8'h31
`define NRPS_CMD_READ_LAST    8'h3F
`define NRPS_CMD_MULTI_READ   8'h60
`define NRPS_CMD_PROG_SETUP   8'h80
`define NRPS_CMD_PROG_SETUP2  8'h81
`define NRPS_CMD_COL_CHANGE   8'h85
`define NRPS_CMD_PROG_START   8'h10
`define NRPS_CMD_PROG_DIST    8'h11
`define NRPS_CMD_PROG_CACHE   8'h15
`define NRPS_CMD_STATUS       8'h70
`define NRPS_CMD_RESET        8'hFF
// register byte offsets on the ahb side
`define NRPS_OFF_CTRL         8'h00
`define NRPS_OFF_ADDR         8'h04
`define NRPS_OFF_WDATA        8'h08
`define NRPS_OFF_RDATA        8'h0C
`define NRPS_OFF_STATUS       8'h10
// ctrl field layout
`define NRPS_CTRL_OP_LSB      0
`define NRPS_CTRL_CMD_LSB     8
`define NRPS_CTRL_CE_BIT      16
`define NRPS_CTRL_WP_BIT      17
// op encodings
`define NRPS_OP_CMD           3'h1
`define NRPS_OP_ADDR5         3'h2
`define NRPS_OP_ADDR2         3'h3
`define NRPS_OP_WRITE         3'h4
`define NRPS_OP_READ          3'h5
`define NRPS_OP_WAITRDY       3'h6
// strobe timing, in ns
`define NRPS_CLK_NS           40
`define NRPS_STROBE_LOW_NS    25
`define NRPS_STROBE_HIGH_NS   15
// status byte bit positions
`define NRPS_ST_FAIL_CUR      0
`define NRPS_ST_FAIL_PREV     1
`define NRPS_ST_PB_READY      5
`define NRPS_ST_DC_READY      6
`endif

// ===== verilog/nrps_pkg.sv
// types shared by the nand sequencer host controller
// assumes nrps_cfg.svh is on the include path
package nrps_pkg;
`include "nrps_cfg.svh"
   typedef struct packed {
      logic       cmdLatch;
      logic       addrLatch;
      logic       chipEnN;
      logic       writeStrobeN;
      logic       readStrobeN;
      logic       writeProtN;
      logic [7:0] dataOut;
      logic       dataOe;
   } nrps_pins_s;
   typedef enum logic [2:0] {
      NRPS_IDLE  = 3'b000,
      NRPS_SETUP = 3'b001,
      NRPS_LOW   = 3'b010,
      NRPS_HIGH  = 3'b011,
      NRPS_WAIT  = 3'b100
   } nrps_state_e;
endpackage

// ===== verilog/nrps_strobe_timer.sv
// strobe phase timer: counts a phase length in ref_clk cycles
// assumes a synchronous start pulse and a constant length
`timescale 1ns/1ps
module nrps_strobe_timer
   import nrps_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] length,
   output logic                  done
);
   logic [WIDTH-1:0] count_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
      end else if (start) begin
         count_reg <= length;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   // done also when idle so a zero length never stalls; it ignores start,
   // since the caller derives start from done and would loop back
   assign done = (count_reg == '0);
endmodule

// ===== verilog/nrps_host.sv
// host controller driving a nand flash over its strobed byte port
// assumes ready_busy_out is pulled up and sampled on ref_clk
// Notes on behaviour
// - read: 00h, five address bytes, 30h
// - restart cached read on block change
// - multi read: one block per district, same page
// - multi read: 60h, 60h, then 30h
// - keep write protect high during multi read
// - 85h plus two bytes moves column
// - between 11h and 81h only 70h or FFh
// - cached program ends with 10h
// - command with cle, address with ale
// - address is five bytes: two column, three row
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "nrps_cfg.svh"
module nrps_host
   import nrps_pkg::*;
#(
   parameter int STROBE_W = 4
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hsel,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output nrps_pins_s       flashPins,
   input  wire logic [7:0]  dataIn,
   input  wire logic        ready_busy_out
);
   localparam int LOW_CYC  =
      (`NRPS_STROBE_LOW_NS + `NRPS_CLK_NS - 1) / `NRPS_CLK_NS;
   localparam int HIGH_CYC =
      (`NRPS_STROBE_HIGH_NS + `NRPS_CLK_NS - 1) / `NRPS_CLK_NS;

   nrps_state_e state_reg;
   logic [2:0]  op_reg;
   logic [7:0]  cmd_reg;
   logic [39:0] addr_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  rdata_reg;
   logic [2:0]  byteIdx_reg;
   logic [2:0]  byteCnt_reg;
   logic        ce_reg;
   logic        wp_reg;
   logic        busyOp_reg;
   logic        apWrite_reg;
   logic [7:0]  apAddr_reg;
   logic        timerStart;
   logic [STROBE_W-1:0] timerLen;
   logic        timerDone;
   logic        isRead;
   logic        launch;
   logic [2:0]  launchOp;
   logic [7:0]  launchCmd;
   logic        cmdBlocked;
   logic        distPend_reg;
   logic        moreBytes;
   logic [2:0]  outIdx;

   // decode used for bus reads only; the write path compares apAddr_reg directly
   function automatic logic [31:0] read_mux(input logic [7:0] off,
      input logic [31:0] ctrl, input logic [31:0] adr,
      input logic [7:0] rd, input logic [31:0] st);
      case (off)
         `NRPS_OFF_CTRL:   read_mux = ctrl;
         `NRPS_OFF_ADDR:   read_mux = adr;
         `NRPS_OFF_RDATA:  read_mux = {24'h000000, rd};
         `NRPS_OFF_STATUS: read_mux = st;
         default:          read_mux = 32'h00000000;
      endcase
   endfunction

   nrps_strobe_timer #(
      .WIDTH (STROBE_W)
   ) u_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .start   (timerStart),
      .length  (timerLen),
      .done    (timerDone)
   );

   // address phase capture; the slave answers with zero wait states
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         apWrite_reg <= 1'b0;
         apAddr_reg  <= 8'h00;
      end else if (hready) begin
         apWrite_reg <= hsel && htrans[1] && hwrite;
         apAddr_reg  <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign launch    = apWrite_reg && (apAddr_reg == `NRPS_OFF_CTRL)
                      && (state_reg == NRPS_IDLE) && !cmdBlocked;
   assign launchOp  = hwdata[`NRPS_CTRL_OP_LSB +: 3];
   assign launchCmd = hwdata[`NRPS_CTRL_CMD_LSB +: 8];
   // between 11h and 81h the only commands let out are status read and reset; other ops are not blocked
   assign cmdBlocked = distPend_reg && (launchOp == `NRPS_OP_CMD) &&
                       (launchCmd != `NRPS_CMD_PROG_SETUP2) &&
                       (launchCmd != `NRPS_CMD_STATUS) &&
                       (launchCmd != `NRPS_CMD_RESET);

   // a status read leaves the pending second district untouched
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         distPend_reg <= 1'b0;
      end else if (launch && launchOp == `NRPS_OP_CMD &&
                   launchCmd != `NRPS_CMD_STATUS) begin
         distPend_reg <= (launchCmd == `NRPS_CMD_PROG_DIST);
      end
   end

   always_comb begin
      hrdata = read_mux(apAddr_reg,
         {14'h0000, wp_reg, ce_reg, cmd_reg, 5'h00, op_reg},
         addr_reg[31:0], rdata_reg,
         {30'h00000000, ready_busy_out, state_reg != NRPS_IDLE});
   end

   // software-written steering registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg  <= 40'h0000000000;
         wdata_reg <= 8'h00;
         ce_reg    <= 1'b0;
         wp_reg    <= 1'b0;
      end else if (apWrite_reg) begin
         if (apAddr_reg == `NRPS_OFF_ADDR) begin
            // software reloads the row per district and block
            addr_reg <= {8'h00, hwdata};  // row byte 2 from bits 31:24, row byte 3 zero
         end
         if (apAddr_reg == `NRPS_OFF_WDATA) begin
            wdata_reg <= hwdata[7:0];
         end
         if (apAddr_reg == `NRPS_OFF_CTRL) begin
            ce_reg <= hwdata[`NRPS_CTRL_CE_BIT];
            wp_reg <= hwdata[`NRPS_CTRL_WP_BIT];
         end
      end
   end

   assign isRead = (op_reg == `NRPS_OP_READ);

   // strobe sequencer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg   <= NRPS_IDLE;
         op_reg      <= 3'h0;
         cmd_reg     <= 8'h00;
         byteIdx_reg <= 3'h0;
         byteCnt_reg <= 3'h0;
         busyOp_reg  <= 1'b0;
      end else begin
         case (state_reg)
            NRPS_IDLE: begin
               if (launch) begin
                  op_reg      <= launchOp;
                  cmd_reg     <= hwdata[`NRPS_CTRL_CMD_LSB +: 8];
                  byteIdx_reg <= 3'h0;
                  // five address bytes, two after 85h
                  byteCnt_reg <= (launchOp == `NRPS_OP_ADDR5) ? 3'h5 :
                                 (launchOp == `NRPS_OP_ADDR2) ? 3'h2 :
                                 3'h1;
                  state_reg   <= (launchOp == `NRPS_OP_WAITRDY) ?
                                 NRPS_WAIT : NRPS_SETUP;
               end
            end
            NRPS_SETUP: begin
               state_reg <= NRPS_LOW;
            end
            NRPS_LOW: begin
               if (timerDone) begin
                  state_reg <= NRPS_HIGH;
               end
            end
            NRPS_HIGH: begin
               if (timerDone) begin
                  if (byteIdx_reg + 3'h1 < byteCnt_reg) begin
                     byteIdx_reg <= byteIdx_reg + 3'h1;
                     state_reg   <= NRPS_LOW;
                  end else begin
                     busyOp_reg <= (op_reg == `NRPS_OP_CMD) &&
                        (cmd_reg == `NRPS_CMD_READ_START ||
                         cmd_reg == `NRPS_CMD_READ_CACHE ||
                         cmd_reg == `NRPS_CMD_READ_LAST  ||
                         cmd_reg == `NRPS_CMD_PROG_START ||
                         cmd_reg == `NRPS_CMD_PROG_DIST  ||
                         cmd_reg == `NRPS_CMD_PROG_CACHE ||
                         cmd_reg == `NRPS_CMD_RESET);
                     state_reg <= NRPS_WAIT;
                  end
               end
            end
            NRPS_WAIT: begin
               // after a busy command or waitrdy, hold off until device releases busy; other ops return to idle at once
               if (ready_busy_out || !(busyOp_reg ||
                   op_reg == `NRPS_OP_WAITRDY)) begin
                  busyOp_reg <= 1'b0;
                  state_reg  <= NRPS_IDLE;
               end
            end
            default: state_reg <= NRPS_IDLE;
         endcase
      end
   end

   // read byte capture at end of the low phase; status repeats
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else if (state_reg == NRPS_LOW && timerDone && isRead) begin
         rdata_reg <= dataIn;
      end
   end

   assign timerStart = (state_reg == NRPS_SETUP) ||
                       (state_reg == NRPS_LOW && timerDone) ||
                       (state_reg == NRPS_HIGH && timerDone &&
                        byteIdx_reg + 3'h1 < byteCnt_reg);
   assign timerLen   = (state_reg == NRPS_LOW) ?
                       STROBE_W'(HIGH_CYC) : STROBE_W'(LOW_CYC);

   // next address byte goes out while the strobe is still high, so the
   // port is settled a full cycle before the strobe falls
   assign moreBytes = (byteIdx_reg + 3'h1 < byteCnt_reg);
   assign outIdx    = (state_reg == NRPS_HIGH && timerDone && moreBytes) ?
                      byteIdx_reg + 3'h1 : byteIdx_reg;

   // pin drive; strobes fall only in the low phase
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flashPins <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipEnN: 1'b1,
                        writeStrobeN: 1'b1, readStrobeN: 1'b1,
                        writeProtN: 1'b0, dataOut: 8'h00, dataOe: 1'b0};
      end else begin
         flashPins.chipEnN    <= !ce_reg;
         flashPins.writeProtN <= wp_reg;
         // latch enables frame the write strobe
         flashPins.cmdLatch   <= (state_reg != NRPS_IDLE) &&
                                 (op_reg == `NRPS_OP_CMD);
         flashPins.addrLatch  <= (state_reg != NRPS_IDLE) &&
                                 (op_reg == `NRPS_OP_ADDR5 ||
                                  op_reg == `NRPS_OP_ADDR2);
         flashPins.writeStrobeN <= !(state_reg == NRPS_LOW &&
                                     !timerDone && !isRead);
         flashPins.readStrobeN  <= !(state_reg == NRPS_LOW &&
                                     !timerDone && isRead);
         flashPins.dataOe <= (state_reg == NRPS_SETUP ||
                              state_reg == NRPS_LOW ||
                              state_reg == NRPS_HIGH) && !isRead;
         case (op_reg)
            `NRPS_OP_CMD:   flashPins.dataOut <= cmd_reg;
            `NRPS_OP_ADDR5,
            `NRPS_OP_ADDR2: flashPins.dataOut <= addr_reg[outIdx*8 +: 8];
            default:        flashPins.dataOut <= wdata_reg;
         endcase
      end
   end
endmodule

// ===== tb/nrps_host_props.sv
// pin sequencing checker for the nand host controller
// assumes one ref_clk domain and a bind onto nrps_host
`timescale 1ns/1ps
module nrps_host_props
   import nrps_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire nrps_pins_s flashPins,
   input wire logic       ready_busy_out
);
   wire nrps_pins_s p = flashPins;
   logic            waitRb;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // only commands that start an array operation, and reset, oblige the host to wait
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         waitRb <= 1'h0;
      end else begin
         waitRb <= ($rose(p.writeStrobeN) && p.cmdLatch &&
                    p.dataOut inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'h11,
                                      8'h15, 8'hFF})
                   || (waitRb && !ready_busy_out);
      end
   end
   property p_latchExcl; !(p.cmdLatch && p.addrLatch); endproperty
   a_latchExcl: assert property (p_latchExcl)
      else $error("both latch enables high");
   property p_strobeData;
      $fell(p.writeStrobeN) |-> p.dataOe && !p.chipEnN;
   endproperty
   a_strobeData: assert property (p_strobeData)
      else $error("write strobe without driven port");
   property p_weShort; $fell(p.writeStrobeN) |=> p.writeStrobeN; endproperty
   a_weShort: assert property (p_weShort)
      else $error("write strobe low too long");
   property p_weHold;
      !p.writeStrobeN |-> $stable(p.dataOut) && $stable(p.cmdLatch)
                          && $stable(p.addrLatch);
   endproperty
   a_weHold: assert property (p_weHold)
      else $error("port changed under write strobe");
   property p_busyHold; waitRb |-> p.writeStrobeN && p.readStrobeN; endproperty
   a_busyHold: assert property (p_busyHold)
      else $error("strobe while device busy");
   property p_ceRead;
      !p.readStrobeN |-> !p.chipEnN && !p.dataOe && !p.cmdLatch
                         && !p.addrLatch;
   endproperty
   a_ceRead: assert property (p_ceRead)
      else $error("read strobe in wrong mode");
   property p_reShort;
      $fell(p.readStrobeN) |=> $rose(p.readStrobeN);
   endproperty
   a_reShort: assert property (p_reShort)
      else $error("read strobe low too long");
   property p_weIdle; !p.writeStrobeN |-> p.readStrobeN; endproperty
   a_weIdle: assert property (p_weIdle)
      else $error("both strobes low");
   c_cmd: cover property ($fell(p.writeStrobeN) && p.cmdLatch);
   c_addr: cover property ($fell(p.writeStrobeN) && p.addrLatch);
   c_read: cover property ($fell(p.readStrobeN));
endmodule
bind nrps_host nrps_host_props u_props (
   .ref_clk        (ref_clk),
   .rstn           (rstn),
   .flashPins      (flashPins),
   .ready_busy_out (ready_busy_out)
);

// ===== tb/nrps_flash_model.sv
// behavioural nand flash on the far side of the host controller
// assumes the nrps_pins_s pins; busy time is kept short
`timescale 1ns/1ps
module nrps_flash_model
   import nrps_pkg::*;
#(
   parameter int BUSY_NS = 2000
) (
   input  wire nrps_pins_s pins,
   input  wire logic       failProg,
   output logic [7:0]      dout,
   output logic            rb
);
   logic [7:0]  cmd = 8'h00;
   logic [11:0] col = 12'h000;
   logic        fail = 1'h0;
   int          nAddr = 0;
   initial rb = 1'h1;
   initial dout = 8'h00;
   always @(posedge pins.writeStrobeN) begin
      if (!pins.chipEnN && pins.cmdLatch) begin
         if (rb || pins.dataOut inside {8'h70, 8'hFF}) begin
            cmd = pins.dataOut;
            nAddr = 0;
         end
         if (cmd == 8'h10) fail = failProg;
         if (cmd inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'h11, 8'h15,
                         8'hFF}) begin
            // a cached program goes busy for its transfer
            rb = 1'h0;
            #BUSY_NS rb = 1'h1;
         end
      end else if (!pins.chipEnN && pins.addrLatch) begin
         if (nAddr == 0) col[7:0] = pins.dataOut;
         if (nAddr == 1) col[11:8] = pins.dataOut[3:0];
         nAddr++;
      end
   end
   always @(negedge pins.readStrobeN) begin
      if (cmd == 8'h70) begin
         dout = {pins.writeProtN, rb, rb, 4'h0, fail};
      end else begin
         dout = col[7:0];
         col++;
      end
   end
   // a released port shows the inverse so a stale byte never matches
   always @(posedge pins.readStrobeN) dout = ~dout;
endmodule

// ===== tb/tb_nrps_host.sv
// self-checking bench for the nand host controller
// assumes the flash model on the pins and register ops over ahb
`timescale 1ns/1ps
module tb_nrps_host
   import nrps_pkg::*;
;
   logic        ref_clk = 1'h0;
   logic        rstn = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] q;
   logic [31:0] hrdata;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic        failProg = 1'h0;
   logic        hreadyout;
   logic        hresp;
   logic        rb;
   logic [7:0]  dataIn;
   logic [7:0]  exp;
   logic [11:0] col;
   logic [7:0]  row;
   nrps_pins_s  pins;
   int          num_errors = 0;
   int          n_compared = 0;
   logic [10:0] mr [5] = '{11'h160, 11'h200, 11'h160, 11'h200, 11'h130};
   logic [10:0] pg [12] = '{11'h180, 11'h200, 11'h400, 11'h111, 11'h181,
      11'h200, 11'h400, 11'h185, 11'h300, 11'h400, 11'h110, 11'h170};
   always #20 ref_clk = ~ref_clk;
   nrps_host dut (.ref_clk(ref_clk), .rstn(rstn), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hsel(1'h1), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flashPins(pins),
      .dataIn(dataIn), .ready_busy_out(rb));
   nrps_flash_model flash (.pins(pins), .failProg(failProg),
      .dout(dataIn), .rb(rb));
   task automatic results;
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic checkByte(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic hwait;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'h1 && n < 20);
      if (hreadyout !== 1'h1) begin
         checkByte(8'hFF, 8'h00);
         results();
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hwait();
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      q = hrdata;
   endtask
   // every op is polled to completion, which also covers busy waits
   task automatic op(input logic [2:0] o, input logic [7:0] c);
      int n;
      xfer(1'h1, 32'h0, {14'h0, 2'h3, c, 5'h0, o});
      n = 0;
      do begin
         xfer(1'h0, 32'h10, 32'h0);
         n++;
      end while (q[0] !== 1'h0 && n < 200);
      if (q[0] !== 1'h0) begin
         checkByte(8'hEE, 8'h00);
         results();
      end
   endtask
   task automatic rdBytes(input int n);
      repeat (n) begin
         op(3'h5, 8'h0);
         xfer(1'h0, 32'hC, 32'h0);
         checkByte(q[7:0], exp);
         exp++;
      end
   endtask
   initial begin
      void'($urandom(16230));
      repeat (6) @(posedge ref_clk);
      rstn <= 1'h1;
      @(posedge ref_clk);
      xfer(1'h0, 32'h10, 32'h0);
      checkByte({6'h0, q[1:0]}, 8'h02);
      col = 12'($urandom);
      xfer(1'h1, 32'h4, {20'h0, col});
      op(3'h2, 8'h0);
      op(3'h1, 8'h30);
      exp = col[7:0];
      rdBytes(3);
      op(3'h1, 8'h31);
      rdBytes(3);
      op(3'h1, 8'h3F);
      rdBytes(3);
      col = 12'($urandom);
      xfer(1'h1, 32'h4, {20'h0, col});
      foreach (mr[i]) begin
         // second district takes an odd block, same page bits
         if (i == 2) begin
            row = 8'h40;
            xfer(1'h1, 32'h4, {8'h00, row, 4'h0, col});
         end
         op(mr[i][10:8], mr[i][7:0]);
      end
      exp = col[7:0];
      rdBytes(2);
      xfer(1'h1, 32'h8, $urandom);
      for (int f = 0; f < 2; f++) begin
         failProg <= f[0];
         foreach (pg[i]) begin
            // even block for the first district, odd for the second
            if (i == 0 || i == 4) begin
               row = (i == 4) ? 8'h40 : 8'h00;
               xfer(1'h1, 32'h4, {8'h00, row, 4'h0, col});
            end
            op(pg[i][10:8], pg[i][7:0]);
         end
         repeat (2) begin
            op(3'h5, 8'h0);
            xfer(1'h0, 32'hC, 32'h0);
            checkByte(q[7:0], {7'h70, f[0]});
         end
      end
      xfer(1'h1, 32'h14, 32'hFFFF_FFFF);
      xfer(1'h0, 32'h10, 32'h0);
      checkByte({6'h0, q[1:0]}, 8'h02);
      results();
   end
endmodule
